/* pkg/pmr_pkg.sv */
// management register set constants, field positions and carrier types
// assumes a single 200 MHz clock domain for all users of this package
package pmr_pkg;

   // register addresses on the management frame
   localparam logic [4:0] REG_CONTROL   = 5'h00;
   localparam logic [4:0] REG_STATUS    = 5'h01;
   localparam logic [4:0] REG_ID_HIGH   = 5'h02;
   localparam logic [4:0] REG_ID_LOW    = 5'h03;
   localparam logic [4:0] REG_ADVERTISE = 5'h04;
   localparam logic [4:0] REG_PARTNER   = 5'h05;
   localparam logic [4:0] REG_EXPANSION = 5'h06;

   // frame fields
   localparam logic [4:0] PHY_ADDRESS   = 5'h10;
   localparam logic [1:0] OP_READ       = 2'h2;
   localparam logic [1:0] OP_WRITE      = 2'h1;
   localparam logic [5:0] PREAMBLE_LEN  = 6'h20;
   localparam logic [3:0] HDR_LAST      = 4'hb;
   localparam logic [3:0] TA_LAST       = 4'h1;
   localparam logic [3:0] DATA_LAST     = 4'hf;

   // control bit positions
   localparam int CTL_RESET     = 15;
   localparam int CTL_LOOPBACK  = 14;
   localparam int CTL_SPEED     = 13;
   localparam int CTL_AN_ENABLE = 12;
   localparam int CTL_POWERDOWN = 11;
   localparam int CTL_ISOLATE   = 10;
   localparam int CTL_RESTART   = 9;
   localparam int CTL_DUPLEX    = 8;
   localparam int CTL_COLTEST   = 7;

   // advertisement bit positions
   localparam int ADV_NEXT_PAGE = 15;
   localparam int ADV_ACK       = 14;
   localparam int ADV_FAULT     = 13;
   localparam int ADV_PAUSE     = 10;
   localparam int ADV_FOUR_PAIR = 9;

   // reset values, advertise write mask and fixed status bits
   localparam logic [15:0] CONTROL_RESET   = 16'h3100;
   localparam logic [15:0] ADV_WR_MASK     = 16'h25ff;
   localparam logic [15:0] ADVERTISE_RESET = 16'h01e1;
   localparam logic [15:0] STATUS_FIXED    = 16'h7809;

   // frame receiver states
   typedef enum logic [2:0] {
      ST_PRE,
      ST_START,
      ST_HDR,
      ST_TA,
      ST_DATA
   } pmr_state_t;

   // conditions reported by the phy core
   typedef struct packed {
      logic link_up;
      logic remote_fault;
      logic jabber;
      logic an_complete;
      logic an_ack;
      logic parallel_fault;
      logic page_rx;
      logic partner_an_able;
   } pmr_event_t;

   // mode controls handed to the phy core
   typedef struct packed {
      logic loopback;
      logic power_down;
      logic isolate;
      logic restart_an;
      logic an_enable;
      logic full_duplex;
      logic speed_100;
      logic collision_test;
   } pmr_mode_t;

endpackage

/* hdl/pmr_register_set.sv */
// management frame slave on mdc/mdio with the basic and
// auto-negotiation register set of a 10/100 phy
// assumes mdc/mdio come from outside the clock domain; phy core
// event and partner inputs are on i_ref_clk
//
// Overview of operation
// - control bit 8 selects full duplex when 1; resets to 1
// - control bit 7 enables collision test when 1; resets to 0
// - status 15 reads 0, bits 14 to 11 read 1
// - status bit 6 reads 0; frames without full preamble are ignored
// - status bit 5 shows auto-negotiation complete live from the phy core input, not registered
// - status bit 4 latches remote fault until read or reset
// - status bit 3 reads 1, auto-negotiation able
// - status bit 2 is latching-low link indicator, resets to 0
// - status bit 1 latches jabber detection
// - status bit 0 reads 1, extended registers present
// - identifier high returns organisation id bits 3 to 18
// - identifier low returns org id 19-24, model, revision
// - advertise bits 15 and 9 read fixed 0
// - advertise 14 shows partner ack; bit 13 writable local fault
// - advertise bit 10 writable pause, resets 0
// - advertise bits 8 to 5 writable ability bits, reset 1
// - advertise selector bits 4:0 reset to 0_0001
// - partner ability is read-only, resets zero, mirrors partner word
// - expansion bit 4 latches parallel detection fault
// - expansion bit 1 latches new page received
// - expansion bit 2 reads 0; bit 3 shows partner next page
// - expansion bit 0 shows partner autoneg able; 15:5 read 0
// - only frames to phy address 1_0000 are answered
// - read: first turnaround released, second driven 0
// - with autoneg enabled, control bits 8 and 13 are ignored
module pmr_register_set #(
   // identity values, arbitrary
   parameter logic [15:0] ORG_ID_UPPER   = 16'h0a5c,
   parameter logic [5:0]  ORG_ID_LOWER   = 6'h2a,
   parameter logic [5:0]  MODEL_NUMBER   = 6'h11,
   parameter logic [3:0]  MODEL_REVISION = 4'h3
) (
   // clock and reset
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst_n,
   // management pins
   input  wire logic               i_mdc,
   input  wire logic               i_mdio,
   output logic                    o_mdio,
   output logic                    o_mdio_oe,
   // phy core status
   input  wire pmr_pkg::pmr_event_t i_event,
   input  wire logic               i_partner_valid,
   input  wire logic [15:0]        i_partner_word,
   input  wire logic               i_an_full_duplex,
   input  wire logic               i_an_speed_100,
   // phy core controls
   output pmr_pkg::pmr_mode_t      o_mode,
   output logic [15:0]             o_advertise
);

   // pin synchronisers
   logic [2:0]          mdc_sync_q;
   logic [2:0]          mdio_sync_q;
   logic                mdc_f_q;
   logic                mdio_f_q;
   logic                mdc_rise;
   logic                bit_in;

   // frame receiver
   pmr_pkg::pmr_state_t st_q;
   logic [5:0]          pre_q;
   logic [3:0]          cnt_q;
   logic [11:0]         hdr_q;
   logic [11:0]         hdr_d;
   logic [4:0]          reg_q;
   logic                is_rd_q;
   logic                sel_q;
   logic [15:0]         sh_q;
   logic                rd_stb;
   logic                wr_stb;
   logic [15:0]         wr_data;
   logic [15:0]         rd_data;

   // register state
   logic [15:0]         ctl_q;
   logic [15:0]         adv_q;
   logic [15:0]         partner_q;
   logic                rfault_q;
   logic                jabber_q;
   logic                link_q;
   logic                pdf_q;
   logic                page_q;
   logic                clr_status;
   logic                clr_expansion;
   logic                soft_reset;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         mdc_sync_q  <= 3'h0;
         mdio_sync_q <= 3'h7;
         mdc_f_q     <= 1'b0;
         mdio_f_q    <= 1'b1;
      end else begin
         mdc_sync_q  <= {mdc_sync_q[1:0], i_mdc};
         mdio_sync_q <= {mdio_sync_q[1:0], i_mdio};
         if (mdc_sync_q[1] == mdc_sync_q[2]) begin
            mdc_f_q <= mdc_sync_q[2];
         end
         if (mdio_sync_q[1] == mdio_sync_q[2]) begin
            mdio_f_q <= mdio_sync_q[2];
         end
      end
   end

   assign mdc_rise = mdc_sync_q[1] & mdc_sync_q[2] & ~mdc_f_q;
   assign bit_in   = mdio_f_q;
   assign hdr_d    = {hdr_q[10:0], bit_in};

   // frame sequencing
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         st_q    <= pmr_pkg::ST_PRE;
         pre_q   <= 6'h00;
         cnt_q   <= 4'h0;
         hdr_q   <= 12'h000;
         reg_q   <= 5'h00;
         is_rd_q <= 1'b0;
         sel_q   <= 1'b0;
      end else if (mdc_rise) begin
         case (st_q)
            pmr_pkg::ST_PRE: begin
               if (bit_in) begin
                  if (pre_q != pmr_pkg::PREAMBLE_LEN) begin
                     pre_q <= pre_q + 6'h01;
                  end
               end else if (pre_q == pmr_pkg::PREAMBLE_LEN) begin
                  st_q  <= pmr_pkg::ST_START;
                  pre_q <= 6'h00;
               end else begin
                  pre_q <= 6'h00;
               end
            end
            pmr_pkg::ST_START: begin
               cnt_q <= 4'h0;
               st_q  <= bit_in ? pmr_pkg::ST_HDR : pmr_pkg::ST_PRE;
            end
            pmr_pkg::ST_HDR: begin
               hdr_q <= hdr_d;
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == pmr_pkg::HDR_LAST) begin
                  cnt_q   <= 4'h0;
                  reg_q   <= hdr_d[4:0];
                  is_rd_q <= hdr_d[11:10] == pmr_pkg::OP_READ;
                  sel_q   <= hdr_d[9:5] == pmr_pkg::PHY_ADDRESS;
                  if (hdr_d[11:10] == pmr_pkg::OP_READ ||
                      hdr_d[11:10] == pmr_pkg::OP_WRITE) begin
                     st_q <= pmr_pkg::ST_TA;
                  end else begin
                     st_q <= pmr_pkg::ST_PRE;
                  end
               end
            end
            pmr_pkg::ST_TA: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == pmr_pkg::TA_LAST) begin
                  cnt_q <= 4'h0;
                  st_q  <= pmr_pkg::ST_DATA;
               end
            end
            pmr_pkg::ST_DATA: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == pmr_pkg::DATA_LAST) begin
                  cnt_q <= 4'h0;
                  st_q  <= pmr_pkg::ST_PRE;
               end
            end
            default: begin
               st_q <= pmr_pkg::ST_PRE;
            end
         endcase
      end
   end

   assign rd_stb = mdc_rise && st_q == pmr_pkg::ST_TA &&
                   cnt_q == pmr_pkg::TA_LAST && is_rd_q && sel_q;
   assign wr_stb = mdc_rise && st_q == pmr_pkg::ST_DATA &&
                   cnt_q == pmr_pkg::DATA_LAST && !is_rd_q && sel_q;
   assign wr_data = {sh_q[14:0], bit_in};

   // data shifter and mdio driver
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         sh_q      <= 16'h0000;
         o_mdio    <= 1'b0;
         o_mdio_oe <= 1'b0;
      end else if (mdc_rise) begin
         if (st_q == pmr_pkg::ST_TA && is_rd_q && sel_q) begin
            if (cnt_q == pmr_pkg::TA_LAST) begin
               sh_q   <= rd_data;
               o_mdio <= rd_data[15];
            end else begin
               o_mdio_oe <= 1'b1;
               o_mdio    <= 1'b0;
            end
         end else if (st_q == pmr_pkg::ST_DATA) begin
            // unselected reads keep o_mdio low while the line is released
            if (is_rd_q && sel_q) begin
               sh_q   <= {sh_q[14:0], 1'b0};
               o_mdio <= sh_q[14];
               if (cnt_q == pmr_pkg::DATA_LAST) begin
                  o_mdio_oe <= 1'b0;
                  o_mdio    <= 1'b0;
               end
            end else begin
               sh_q <= wr_data;
            end
         end else begin
            o_mdio_oe <= 1'b0;
            o_mdio    <= 1'b0;
         end
      end
   end

   // read multiplexer
   always_comb begin
      rd_data = 16'h0000;
      case (reg_q)
         pmr_pkg::REG_CONTROL: begin
            rd_data = ctl_q;
         end
         pmr_pkg::REG_STATUS: begin
            rd_data = pmr_pkg::STATUS_FIXED;
            rd_data[6] = 1'b0;
            rd_data[5] = i_event.an_complete;
            rd_data[4] = rfault_q;
            rd_data[2] = link_q;
            rd_data[1] = jabber_q;
         end
         pmr_pkg::REG_ID_HIGH: begin
            rd_data = ORG_ID_UPPER;
         end
         pmr_pkg::REG_ID_LOW: begin
            rd_data = {ORG_ID_LOWER, MODEL_NUMBER, MODEL_REVISION};
         end
         pmr_pkg::REG_ADVERTISE: begin
            rd_data = adv_q & pmr_pkg::ADV_WR_MASK;
            rd_data[pmr_pkg::ADV_NEXT_PAGE] = 1'b0;
            rd_data[pmr_pkg::ADV_FOUR_PAIR] = 1'b0;
            rd_data[pmr_pkg::ADV_ACK] = i_event.an_ack;
         end
         pmr_pkg::REG_PARTNER: begin
            rd_data = partner_q;
         end
         pmr_pkg::REG_EXPANSION: begin
            rd_data[4] = pdf_q;
            rd_data[3] = partner_q[pmr_pkg::ADV_NEXT_PAGE];
            rd_data[2] = 1'b0;
            rd_data[1] = page_q;
            rd_data[0] = i_event.partner_an_able;
         end
         default: begin
            rd_data = 16'h0000;
         end
      endcase
   end

   assign clr_status    = rd_stb && reg_q == pmr_pkg::REG_STATUS;
   assign clr_expansion = rd_stb && reg_q == pmr_pkg::REG_EXPANSION;
   assign soft_reset    = wr_stb && reg_q == pmr_pkg::REG_CONTROL &&
                          wr_data[pmr_pkg::CTL_RESET];

   // writable control and advertisement
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || soft_reset) begin
         ctl_q <= pmr_pkg::CONTROL_RESET;
         adv_q <= pmr_pkg::ADVERTISE_RESET;
      end else begin
         ctl_q[pmr_pkg::CTL_RESTART] <= 1'b0;
         if (wr_stb && reg_q == pmr_pkg::REG_CONTROL) begin
            ctl_q <= {1'b0, wr_data[14:7], 7'h00};
         end
         if (wr_stb && reg_q == pmr_pkg::REG_ADVERTISE) begin
            adv_q <= wr_data & pmr_pkg::ADV_WR_MASK;
         end
      end
   end

   // partner word capture
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         partner_q <= 16'h0000;
      end else if (i_partner_valid) begin
         partner_q <= i_partner_word;
      end
   end

   // latching status flags, a new event wins over the read clear
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         rfault_q <= 1'b0;
         jabber_q <= 1'b0;
         link_q   <= 1'b0;
         pdf_q    <= 1'b0;
         page_q   <= 1'b0;
      end else begin
         rfault_q <= i_event.remote_fault |
                     (rfault_q & ~clr_status);
         jabber_q <= i_event.jabber |
                     (jabber_q & ~clr_status);
         link_q   <= i_event.link_up &
                     (link_q | clr_status);
         pdf_q    <= i_event.parallel_fault |
                     (pdf_q & ~clr_expansion);
         page_q   <= i_event.page_rx |
                     (page_q & ~clr_expansion);
      end
   end

   // mode outputs to the phy core
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_mode      <= '0;
         o_advertise <= pmr_pkg::ADVERTISE_RESET;
      end else begin
         o_mode.loopback       <= ctl_q[pmr_pkg::CTL_LOOPBACK];
         o_mode.power_down     <= ctl_q[pmr_pkg::CTL_POWERDOWN];
         o_mode.isolate        <= ctl_q[pmr_pkg::CTL_ISOLATE];
         o_mode.restart_an     <= ctl_q[pmr_pkg::CTL_RESTART];
         o_mode.an_enable      <= ctl_q[pmr_pkg::CTL_AN_ENABLE];
         o_mode.collision_test <= ctl_q[pmr_pkg::CTL_COLTEST];
         if (ctl_q[pmr_pkg::CTL_AN_ENABLE]) begin
            o_mode.full_duplex <= i_an_full_duplex;
            o_mode.speed_100   <= i_an_speed_100;
         end else begin
            o_mode.full_duplex <= ctl_q[pmr_pkg::CTL_DUPLEX];
            o_mode.speed_100   <= ctl_q[pmr_pkg::CTL_SPEED];
         end
         o_advertise <= adv_q;
      end
   end

endmodule

/* sim/pmr_register_set_sva.sv */
// concurrent checks on the management pins and mode outputs
// assumes bind into pmr_register_set and the 200 MHz i_ref_clk domain
module pmr_register_set_sva (
   // clock and reset
   input wire logic               i_ref_clk,
   input wire logic               i_rst_n,
   // watched pins
   input wire logic               i_mdc,
   input wire logic               i_an_full_duplex,
   input wire logic               i_an_speed_100,
   input wire logic               o_mdio,
   input wire logic               o_mdio_oe,
   input wire pmr_pkg::pmr_mode_t o_mode,
   input wire logic [15:0]        o_advertise
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       mdc_q;
   logic [4:0] rises_q;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         mdc_q <= 1'h0;
      end else begin
         mdc_q <= i_mdc;
      end
   end

   // mdc rises seen while the device drives the line
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || !o_mdio_oe) begin
         rises_q <= 5'h00;
      end else if (i_mdc && !mdc_q) begin
         rises_q <= rises_q + 5'h01;
      end
   end

   ta_drive_zero_a: assert property ($rose(o_mdio_oe) |-> !o_mdio)
      else $error("turnaround not driven low");
   drive_start_a: assert property (
      $rose(o_mdio_oe) |-> i_mdc && $past(i_mdc, 2))
      else $error("drive started away from an mdc high phase");
   frame_length_a: assert property (
      $fell(o_mdio_oe) |-> rises_q == 5'h11)
      else $error("read drive did not last seventeen mdc rises");
   restart_pulse_a: assert property (
      o_mode.restart_an |=> !o_mode.restart_an)
      else $error("restart did not clear itself");
   an_duplex_a: assert property (
      o_mode.an_enable && $stable(i_an_full_duplex) &&
      $past(i_an_full_duplex, 2) == i_an_full_duplex |->
      o_mode.full_duplex == i_an_full_duplex)
      else $error("negotiated duplex not followed");
   an_speed_a: assert property (
      o_mode.an_enable && $stable(i_an_speed_100) &&
      $past(i_an_speed_100, 2) == i_an_speed_100 |->
      o_mode.speed_100 == i_an_speed_100)
      else $error("negotiated speed not followed");
   adv_reset_a: assert property (
      $rose(i_rst_n) |-> o_advertise == 16'h01e1)
      else $error("advertise reset value wrong");
   adv_fixed_a: assert property (
      o_advertise[15] == 1'h0 && o_advertise[9] == 1'h0)
      else $error("fixed advertise bits set");
   mode_reset_a: assert property (
      $rose(i_rst_n) |=> o_mode.an_enable && !o_mode.isolate &&
      !o_mode.collision_test && !o_mode.restart_an)
      else $error("mode defaults wrong after reset");

   read_frame_c: cover property ($fell(o_mdio_oe));
   restart_c: cover property (o_mode.restart_an);
   an_off_c: cover property ($fell(o_mode.an_enable));
endmodule

bind pmr_register_set pmr_register_set_sva chk_u (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_mdc(i_mdc),
   .i_an_full_duplex(i_an_full_duplex), .i_an_speed_100(i_an_speed_100),
   .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe), .o_mode(o_mode),
   .o_advertise(o_advertise));

/* sim/pmr_station.sv */
// station management model driving whole frames on mdc and mdio
// assumes the bench resolves the shared line with a pull-up
module pmr_station (
   // line as seen on the pin
   input  wire logic i_mdio_pin,
   // station drive
   output logic      o_mdc,
   output logic      o_mdio,
   output logic      o_mdio_en
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      o_mdc = 1'h0;
      o_mdio = 1'h0;
      o_mdio_en = 1'h0;
   end

   // data changes in the low phase and holds 32 ns past the rise
   task automatic put(input logic b);
      o_mdio = b;
      o_mdio_en = 1'h1;
      #32 o_mdc = 1'h1;
      #32 o_mdc = 1'h0;
   endtask

   // line released; the device bit is taken late in the slot
   task automatic get(output logic b);
      o_mdio_en = 1'h0;
      o_mdio = ~o_mdio;
      #32 o_mdc = 1'h1;
      #32 b = i_mdio_pin;
      o_mdc = 1'h0;
   endtask

   // one frame; mdc stands low between frames
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] rg, input logic [15:0] wd, input int pre,
      output logic ta, output logic [15:0] rd);
      logic [13:0] hdr;
      logic        last;
      hdr = {2'h1, op, phy, rg};
      rd = wd;
      ta = 1'h0;
      #1.3;
      for (int i = 0; i < pre; i++) put(1'h1);
      for (int i = 13; i >= 0; i--) put(hdr[i]);
      if (op == 2'h2) begin
         get(ta);
         for (int i = 15; i >= 0; i--) get(rd[i]);
         get(last);
      end else begin
         put(1'h1);
         put(1'h0);
         for (int i = 15; i >= 0; i--) put(wd[i]);
      end
      o_mdio_en = 1'h0;
   endtask
endmodule

/* sim/phy_mgmt_register_set_tb.sv */
// self-checking bench for the management register set
// assumes the station model and a pull-up on the shared mdio line
module phy_mgmt_register_set_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // identity values, arbitrary
   localparam logic [15:0] ID_HI = 16'h1c2d;
   localparam logic [5:0]  ID_LO = 6'h15;
   localparam logic [5:0]  ID_MD = 6'h0b;
   localparam logic [3:0]  ID_RV = 4'h6;
   logic                i_ref_clk;
   logic                i_rst_n;
   logic                mdc;
   logic                st_mdio;
   logic                st_en;
   logic                mdio_wire;
   logic                dut_mdio;
   logic                dut_oe;
   pmr_pkg::pmr_event_t ev;
   logic                i_partner_valid;
   logic [15:0]         i_partner_word;
   logic                an_fd;
   logic                an_sp;
   pmr_pkg::pmr_mode_t  o_mode;
   logic [15:0]         o_advertise;
   logic [15:0]         w;
   logic [15:0]         m;
   logic [15:0]         d;
   logic                ta;
   int                  seed;
   int                  mismatches;
   int                  comparisons;

   assign mdio_wire = dut_oe ? dut_mdio : (st_en ? st_mdio : 1'h1);

   pmr_register_set #(.ORG_ID_UPPER(ID_HI), .ORG_ID_LOWER(ID_LO),
      .MODEL_NUMBER(ID_MD), .MODEL_REVISION(ID_RV)) dut_u (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_mdc(mdc),
      .i_mdio(mdio_wire), .o_mdio(dut_mdio), .o_mdio_oe(dut_oe),
      .i_event(ev), .i_partner_valid(i_partner_valid),
      .i_partner_word(i_partner_word), .i_an_full_duplex(an_fd),
      .i_an_speed_100(an_sp), .o_mode(o_mode), .o_advertise(o_advertise));

   pmr_station mgmt_u (.i_mdio_pin(mdio_wire), .o_mdc(mdc),
      .o_mdio(st_mdio), .o_mdio_en(st_en));

   initial begin
      i_ref_clk = 1'h0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end

   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic read_chk(input logic [4:0] rg, input logic [15:0] exp,
                           input string what);
      @(posedge i_ref_clk);
      mgmt_u.xfer(pmr_pkg::OP_READ, pmr_pkg::PHY_ADDRESS, rg, 16'h0000, 32,
                  ta, d);
      check("turnaround", 16'h0000, {15'h0000, ta});
      check(what, exp, d);
   endtask

   task automatic wr(input logic [4:0] rg, input logic [15:0] v);
      @(posedge i_ref_clk);
      mgmt_u.xfer(pmr_pkg::OP_WRITE, pmr_pkg::PHY_ADDRESS, rg, v, 32, ta, d);
   endtask

   // frames the device must ignore; the line stays released
   task automatic refused(input logic [1:0] op, input logic [4:0] phy,
                          input int pre);
      @(posedge i_ref_clk);
      mgmt_u.xfer(op, phy, pmr_pkg::REG_ADVERTISE, 16'h0000, pre, ta, d);
      if (op == pmr_pkg::OP_READ) check("released line", 16'hffff, d);
      check("advertise kept", 16'h01e1, o_advertise);
   endtask

   task automatic pulse(input logic [7:0] msk);
      @(posedge i_ref_clk);
      ev <= pmr_pkg::pmr_event_t'(ev | msk);
      @(posedge i_ref_clk);
      ev <= pmr_pkg::pmr_event_t'(ev & ~msk);
   endtask

   function automatic logic [15:0] exp_status(input logic rf, input logic lk,
                                              input logic jb);
      return 16'h7809 | {10'h000, ev.an_complete, rf, 1'h0, lk, jb, 1'h0};
   endfunction

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #400000;
      mismatches++;
      complete_run();
   end

   initial begin
      seed = 99;
      mismatches = 0;
      comparisons = 0;
      i_rst_n = 1'h0;
      ev = pmr_pkg::pmr_event_t'(8'h00);
      i_partner_valid = 1'h0;
      i_partner_word = 16'h0000;
      an_fd = 1'h0;
      an_sp = 1'h0;
      repeat (6) @(posedge i_ref_clk);
      i_rst_n <= 1'h1;
      repeat (4) @(posedge i_ref_clk);
      read_chk(pmr_pkg::REG_ID_HIGH, ID_HI, "id_high");
      read_chk(pmr_pkg::REG_ID_LOW, {ID_LO, ID_MD, ID_RV}, "id_low");
      $display("test identity done");
      ev.link_up <= 1'h1;
      ev.an_complete <= 1'($random(seed));
      pulse(8'h60);
      w = exp_status(1'h1, 1'h0, 1'h1);
      read_chk(pmr_pkg::REG_STATUS, w, "status");
      w = exp_status(1'h0, 1'h1, 1'h0);
      read_chk(pmr_pkg::REG_STATUS, w, "status");
      @(posedge i_ref_clk);
      ev.link_up <= 1'h0;
      @(posedge i_ref_clk);
      ev.link_up <= 1'h1;
      w = exp_status(1'h0, 1'h0, 1'h0);
      read_chk(pmr_pkg::REG_STATUS, w, "link drop");
      $display("test status done");
      read_chk(pmr_pkg::REG_ADVERTISE, 16'h01e1, "advertise");
      for (int i = 0; i < 4; i++) begin
         w = (i == 0) ? 16'hffff : ((i == 1) ? 16'h0000 : 16'($random(seed)));
         ev.an_ack <= w[3];
         wr(pmr_pkg::REG_ADVERTISE, w);
         check("advertise copy", w & 16'h25ff, o_advertise);
         w = (w & 16'h25ff) | {1'h0, ev.an_ack, 14'h0000};
         read_chk(pmr_pkg::REG_ADVERTISE, w, "advertise");
      end
      $display("test advertise done");
      read_chk(pmr_pkg::REG_PARTNER, 16'h0000, "partner");
      @(posedge i_ref_clk);
      i_partner_word <= 16'($random(seed));
      i_partner_valid <= 1'h1;
      @(posedge i_ref_clk);
      i_partner_valid <= 1'h0;
      w = i_partner_word;
      i_partner_word <= ~w;
      wr(pmr_pkg::REG_PARTNER, ~w);
      read_chk(pmr_pkg::REG_PARTNER, w, "partner");
      ev.partner_an_able <= 1'h1;
      pulse(8'h06);
      w = {11'h000, 1'h1, w[15], 1'h0, 1'h1, 1'h1};
      read_chk(pmr_pkg::REG_EXPANSION, w, "expansion");
      read_chk(pmr_pkg::REG_EXPANSION, w & 16'h0009, "expansion");
      $display("test partner done");
      w = (16'($random(seed)) & 16'h6d80) | 16'h0200;
      for (int i = 0; i < 2; i++) begin
         wr(pmr_pkg::REG_CONTROL, w);
         m = {8'h00, w[14], w[11], w[10], 2'h0, w[8], w[13], w[7]};
         check("mode", m, 16'(o_mode));
         read_chk(pmr_pkg::REG_CONTROL, w & 16'h6d80, "control");
         w = w ^ 16'h6d80;
      end
      an_fd <= ~w[8];
      an_sp <= ~w[13];
      wr(pmr_pkg::REG_CONTROL, w | 16'h1000);
      m = {14'h0000, ~w[8], ~w[13]};
      check("negotiated", m, {14'h0000, o_mode.full_duplex, o_mode.speed_100});
      wr(pmr_pkg::REG_CONTROL, 16'h8000);
      $display("test control done");
      refused(pmr_pkg::OP_WRITE, pmr_pkg::PHY_ADDRESS, 31);
      refused(pmr_pkg::OP_READ, pmr_pkg::PHY_ADDRESS, 31);
      refused(pmr_pkg::OP_READ, 5'h11, 32);
      refused(pmr_pkg::OP_WRITE, 5'h00, 32);
      read_chk(pmr_pkg::REG_ID_HIGH, ID_HI, "id_high");
      $display("test refused done");
      complete_run();
   end
endmodule
